// ---- verilog/iss_core.sv ----
// Purpose: Sample timing, data-ready and 16-bit serial slave port of an inertial sensor.
// Assumes: Pins are asynchronous to mclk; sensor_sample is on mclk.
// Notes:   Frame is W,A[6:0],D[7:0] MSB first; a read answers in the next frame.
// How it works
// - Sample rate follows eight-bit period setting
// - Setting 0x0A up selects low power delays
// - Normal mode: 220, 100, 4 ms delays
// - Data ready 600 us after sync pulse
// - Each sample loads outputs, pulses data ready
// - Shift out on fall, capture on rise
// - Two byte addresses per 16-bit register
`timescale 1ns/10ps
`include "iss_map.svh"
module iss_core import iss_pkg::*; #(
    parameter int unsigned START_NORM_CYC = `ISS_T_START_NORM_MS * `ISS_CLK_KHZ,
    parameter int unsigned START_LP_CYC   = `ISS_T_START_LP_MS * `ISS_CLK_KHZ,
    parameter int unsigned RESET_NORM_CYC = `ISS_T_RESET_NORM_MS * `ISS_CLK_KHZ,
    parameter int unsigned RESET_LP_CYC   = `ISS_T_RESET_LP_MS * `ISS_CLK_KHZ,
    parameter int unsigned SLEEP_NORM_CYC = `ISS_T_SLEEP_NORM_MS * `ISS_CLK_KHZ,
    parameter int unsigned SLEEP_LP_CYC   = `ISS_T_SLEEP_LP_MS * `ISS_CLK_KHZ,
    parameter int unsigned SYNC_DRDY_CYC  = `ISS_T_SYNC_DRDY_US * `ISS_CLK_KHZ / 1000,
    parameter int unsigned BASE_CYC       = `ISS_CLK_KHZ * 10000 / `ISS_BASE_RATE_SPS_X10
) (
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    input  wire logic        spi_sclk,
    input  wire logic        spi_cs_n,
    input  wire logic        spi_din,
    output logic             spi_dout,
    output logic             spi_dout_oe_n,
    input  wire logic        sync_clock_input,
    input  wire logic        ext_sync_enable,
    input  wire logic        reset_pin_n,
    input  wire logic [15:0] sensor_sample,
    output logic             data_ready_pin
);
    localparam int unsigned WAKE_CYC = (`ISS_T_WAKE_PULSE_US * `ISS_CLK_KHZ + 999) / 1000;
    localparam int unsigned START_CYC = (`ISS_PERIOD_RESET >= `ISS_LP_THRESHOLD) ?
                                        START_LP_CYC : START_NORM_CYC;
    // Pin order: 0 sclk, 1 cs_n, 2 din, 3 sync, 4 reset pin.
    logic [4:0]    pin_raw;
    logic [4:0]    pin_s1_ff, pin_s2_ff, pin_s3_ff, pin_ff, pin_d_ff;
    iss_state_type state_ff;
    iss_count_type dly_ff, smp_cnt_ff, sync_cnt_ff, period_cyc;
    logic [9:0]    wake_cnt_ff;
    logic [7:0]    period_ff;
    logic [15:0]   smp_out_ff, smp_num_ff, rx_ff, tx_ff, rd_word_ff;
    logic [7:0]    drdy_cnt_ff;
    logic [3:0]    bit_cnt_ff;
    logic          sync_busy_ff, sleep_req_ff, drdy_ff, dout_ff, dout_oe_n_ff;
    logic          sclk_rise, sclk_fall, cs_fall, sync_rise, rst_pin_fall;
    logic          low_power, ready, frame_done, wr_frame, frm_hi, sample_tick, wake_evt;
    logic [5:0]    frm_idx;
    logic [15:0]   nxt_rd_word, rx_full;
    assign pin_raw = {reset_pin_n, sync_clock_input, spi_din, spi_cs_n, spi_sclk};
    // Each pin counts as changed once the second and third stages agree.
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++) begin : g_pin
            always_ff @(posedge mclk or posedge sys_rst) begin
                if (sys_rst) begin
                    {pin_s1_ff[gi], pin_s2_ff[gi], pin_s3_ff[gi]} <= 3'h7;
                    {pin_ff[gi], pin_d_ff[gi]}                    <= 2'h3;
                end else begin
                    pin_s1_ff[gi] <= pin_raw[gi];
                    pin_s2_ff[gi] <= pin_s1_ff[gi];
                    pin_s3_ff[gi] <= pin_s2_ff[gi];
                    if (pin_s2_ff[gi] == pin_s3_ff[gi]) begin
                        pin_ff[gi] <= pin_s3_ff[gi];
                    end
                    pin_d_ff[gi] <= pin_ff[gi];
                end
            end
        end
    endgenerate
    assign sclk_rise    = pin_ff[0] & ~pin_d_ff[0] & ~pin_ff[1];
    assign sclk_fall    = ~pin_ff[0] & pin_d_ff[0] & ~pin_ff[1];
    assign cs_fall      = ~pin_ff[1] & pin_d_ff[1];
    assign sync_rise    = pin_ff[3] & ~pin_d_ff[3];
    assign rst_pin_fall = ~pin_ff[4] & pin_d_ff[4];
    assign low_power = (period_ff >= `ISS_LP_THRESHOLD);
    assign ready     = (state_ff == ISS_ST_RUN);
    assign wake_evt  = (state_ff == ISS_ST_SLEEP) && (wake_cnt_ff == 10'(WAKE_CYC - 1))
                       && ~pin_ff[1];
    assign period_cyc = 24'((period_ff == 8'h00 ? 8'h01 : period_ff) * BASE_CYC);
    assign sample_tick = ready && (ext_sync_enable ?
                         (sync_busy_ff && sync_cnt_ff == 24'h00_0000) :
                         (smp_cnt_ff == period_cyc - 24'h00_0001));
    // Power-on, reset-pin and sleep recovery delays.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            state_ff <= ISS_ST_WAIT;
            dly_ff   <= 24'(START_CYC - 1);
        end else if (rst_pin_fall) begin
            state_ff <= ISS_ST_WAIT;
            dly_ff   <= low_power ? 24'(RESET_LP_CYC - 1) : 24'(RESET_NORM_CYC - 1);
        end else begin
            unique case (state_ff)
                ISS_ST_WAIT: begin
                    if (dly_ff == 24'h00_0000) begin
                        state_ff <= ISS_ST_RUN;
                    end else begin
                        dly_ff <= dly_ff - 24'h00_0001;
                    end
                end
                ISS_ST_RUN: begin
                    if (sleep_req_ff) begin
                        state_ff <= ISS_ST_SLEEP;
                    end
                end
                ISS_ST_SLEEP: begin
                    if (wake_evt) begin
                        state_ff <= ISS_ST_WAIT;
                        dly_ff   <= low_power ? 24'(SLEEP_LP_CYC - 1) : 24'(SLEEP_NORM_CYC - 1);
                    end
                end
            endcase
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            wake_cnt_ff <= 10'h000;
        end else if (state_ff != ISS_ST_SLEEP || pin_ff[1]) begin
            wake_cnt_ff <= 10'h000;
        end else if (wake_cnt_ff != 10'(WAKE_CYC - 1)) begin
            wake_cnt_ff <= wake_cnt_ff + 10'h001;
        end
    end
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            smp_cnt_ff <= 24'h00_0000;
        end else if (!ready || ext_sync_enable || smp_cnt_ff >= period_cyc - 24'h00_0001) begin
            smp_cnt_ff <= 24'h00_0000;
        end else begin
            smp_cnt_ff <= smp_cnt_ff + 24'h00_0001;
        end
    end
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            sync_busy_ff <= 1'b0;
            sync_cnt_ff  <= 24'h00_0000;
        end else if (ready && ext_sync_enable && sync_rise) begin
            sync_busy_ff <= 1'b1;
            sync_cnt_ff  <= 24'(SYNC_DRDY_CYC - 1);
        end else if (!ready || !ext_sync_enable || sync_cnt_ff == 24'h00_0000) begin
            sync_busy_ff <= 1'b0;
        end else begin
            sync_cnt_ff <= sync_cnt_ff - 24'h00_0001;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            smp_out_ff  <= 16'h0000;
            smp_num_ff  <= 16'h0000;
            drdy_cnt_ff <= 8'h00;
            drdy_ff     <= 1'b0;
        end else if (sample_tick) begin
            smp_out_ff  <= sensor_sample;
            smp_num_ff  <= smp_num_ff + 16'h0001;
            drdy_cnt_ff <= `ISS_DRDY_WIDTH_CYC - 8'h01;
            drdy_ff     <= 1'b1;
        end else if (drdy_cnt_ff != 8'h00) begin
            drdy_cnt_ff <= drdy_cnt_ff - 8'h01;
        end else begin
            drdy_ff <= 1'b0;
        end
    end
    assign rx_full    = {rx_ff[14:0], pin_ff[2]};
    assign frame_done = sclk_rise && (bit_cnt_ff == 4'hF);
    assign wr_frame   = rx_full[`ISS_FRM_WRITE_BIT];
    assign frm_idx    = rx_full[14:9];
    assign frm_hi     = rx_full[8];
    always_comb begin
        nxt_rd_word = 16'h0000;
        unique case (frm_idx)
            `ISS_IDX_SAMPLE:  nxt_rd_word = smp_out_ff;
            `ISS_IDX_COUNT:   nxt_rd_word = smp_num_ff;
            `ISS_IDX_PERIOD:  nxt_rd_word = {8'h00, period_ff};
            `ISS_IDX_CONTROL: nxt_rd_word = {13'h0000, state_ff == ISS_ST_SLEEP, low_power, ready};
            default:          nxt_rd_word = 16'h0000;
        endcase
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            period_ff    <= `ISS_PERIOD_RESET;
            sleep_req_ff <= 1'b0;
        end else begin
            sleep_req_ff <= frame_done && ready && wr_frame && !frm_hi
                            && frm_idx == `ISS_IDX_CONTROL && rx_full[`ISS_CTL_SLEEP_BIT];
            if (frame_done && ready && wr_frame && !frm_hi && frm_idx == `ISS_IDX_PERIOD) begin
                period_ff <= rx_full[7:0];
            end
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_ff         <= 16'h0000;
            tx_ff         <= 16'h0000;
            rd_word_ff    <= 16'h0000;
            bit_cnt_ff    <= 4'h0;
            dout_ff       <= 1'b0;
            dout_oe_n_ff  <= 1'b1;
        end else begin
            dout_oe_n_ff <= pin_ff[1];
            if (cs_fall) begin
                bit_cnt_ff <= 4'h0;
                tx_ff      <= rd_word_ff;
            end else if (sclk_fall) begin
                dout_ff <= tx_ff[15];
                tx_ff   <= {tx_ff[14:0], 1'b0};
            end else if (sclk_rise) begin
                rx_ff      <= rx_full;
                bit_cnt_ff <= bit_cnt_ff + 4'h1;
                if (frame_done) begin
                    rd_word_ff <= (ready && !wr_frame) ? nxt_rd_word : 16'h0000;
                    tx_ff      <= (ready && !wr_frame) ? nxt_rd_word : 16'h0000;
                end
            end
        end
    end

    assign spi_dout       = dout_ff;
    assign spi_dout_oe_n  = dout_oe_n_ff;
    assign data_ready_pin = drdy_ff;

    property p_rate;
        @(posedge mclk) disable iff (sys_rst)
        (ready && !ext_sync_enable && smp_cnt_ff < period_cyc - 24'h00_0001)
            |=> smp_cnt_ff == $past(smp_cnt_ff) + 24'h00_0001;
    endproperty
    a_rate: assert property (p_rate) else $error("Sample tick off period.");
    property p_lp_reset;
        @(posedge mclk) disable iff (sys_rst)
        (rst_pin_fall && low_power) |=> dly_ff == 24'(RESET_LP_CYC - 1) && !ready;
    endproperty
    a_lp_reset: assert property (p_lp_reset) else $error("Low power reset delay wrong.");
    property p_norm_wake;
        @(posedge mclk) disable iff (sys_rst)
        (wake_evt && !low_power && !rst_pin_fall) |=> state_ff == ISS_ST_WAIT
            && dly_ff == 24'(SLEEP_NORM_CYC - 1);
    endproperty
    a_norm_wake: assert property (p_norm_wake) else $error("Sleep recovery delay wrong.");
    property p_sync;
        @(posedge mclk) disable iff (sys_rst)
        (ready && ext_sync_enable && sync_rise && !rst_pin_fall && !sleep_req_ff)
            |=> sync_busy_ff && sync_cnt_ff == 24'(SYNC_DRDY_CYC - 1);
    endproperty
    a_sync: assert property (p_sync) else $error("Sync delay not started.");
    property p_drdy;
        @(posedge mclk) disable iff (sys_rst)
        sample_tick |=> drdy_ff && smp_out_ff == $past(sensor_sample) ##1 drdy_ff;
    endproperty
    a_drdy: assert property (p_drdy) else $error("Data ready or sample missing.");
    property p_shift;
        @(posedge mclk) disable iff (sys_rst)
        (sclk_fall && !cs_fall) |=> dout_ff == $past(tx_ff[15]) && $stable(rx_ff);
    endproperty
    a_shift: assert property (p_shift) else $error("Output bit not shifted on fall.");
    property p_byte_wr;
        @(posedge mclk) disable iff (sys_rst)
        (frame_done && ready && wr_frame && !frm_hi && frm_idx == `ISS_IDX_PERIOD)
            |=> period_ff == $past(rx_full[7:0]);
    endproperty
    a_byte_wr: assert property (p_byte_wr) else $error("Lower byte write lost.");
    property p_not_ready;
        @(posedge mclk) disable iff (sys_rst)
        (frame_done && !ready) |=> $stable(period_ff) && rd_word_ff == 16'h0000;
    endproperty
    a_not_ready: assert property (p_not_ready) else $error("Frame served before ready.");
    c_sample: cover property (@(posedge mclk) disable iff (sys_rst) $rose(drdy_ff));
    c_wake: cover property (@(posedge mclk) disable iff (sys_rst) wake_evt);
    c_write: cover property (@(posedge mclk) disable iff (sys_rst) frame_done && ready && wr_frame);
endmodule

// ---- include/iss_map.svh ----
// Purpose: Offsets, field positions, reset values and timing figures of the sensor port.
// Assumes: Core clock of 20 MHz.
// Notes:   Times keep their printed unit; cycle counts other than ISS_DRDY_WIDTH_CYC are derived in the core.
`ifndef ISS_MAP_SVH
`define ISS_MAP_SVH

`define ISS_CLK_KHZ            20000
`define ISS_BASE_RATE_SPS_X10  8192
`define ISS_T_START_NORM_MS    220
`define ISS_T_START_LP_MS      290
`define ISS_T_RESET_NORM_MS    100
`define ISS_T_RESET_LP_MS      170
`define ISS_T_SLEEP_NORM_MS    4
`define ISS_T_SLEEP_LP_MS      15
`define ISS_T_SYNC_DRDY_US     600
`define ISS_T_WAKE_PULSE_US    20
`define ISS_DRDY_WIDTH_CYC     8'h0A

`define ISS_LP_THRESHOLD       8'h0A
`define ISS_PERIOD_RESET       8'h01

`define ISS_IDX_SAMPLE         6'h00
`define ISS_IDX_COUNT          6'h01
`define ISS_IDX_PERIOD         6'h02
`define ISS_IDX_CONTROL        6'h03

`define ISS_FRM_WRITE_BIT      15
`define ISS_CTL_SLEEP_BIT      0
`define ISS_STS_READY_BIT      0
`define ISS_STS_LOWPWR_BIT     1
`define ISS_STS_SLEEP_BIT      2

`endif

// ---- include/iss_pkg.sv ----
// Purpose: Types shared by the sensor port core.
// Assumes: Constants live in iss_map.svh.
// Notes:   None.
package iss_pkg;
    typedef enum logic [1:0] {
        ISS_ST_WAIT,
        ISS_ST_RUN,
        ISS_ST_SLEEP
    } iss_state_type;
    typedef logic [23:0] iss_count_type;
endpackage

// ---- dv/iss_host.sv ----
// Purpose: Host controller model for the sensor's serial port and sync pin.
// Assumes: Idle-high serial clock, data changed on fall and sampled on rise, MSB first.
// Notes:   Pins change 2 ns after an mclk rise; lp_mode picks the stall length.
`timescale 1ns/10ps
module iss_host #(
    parameter int unsigned HALF_CYC = 10
) (
    input  wire logic mclk,
    output logic      spi_sclk,
    output logic      spi_cs_n,
    output logic      spi_din,
    input  wire logic spi_dout,
    output logic      sync_clock_input
);
    logic   lp_mode = 1'b0;
    longint last_sync = 0;
    initial begin
        spi_sclk = 1'b1;
        spi_cs_n = 1'b1;
        spi_din = 1'b0;
        sync_clock_input = 1'b0;
    end
    // A deselected data line toggles so that a stale bit never looks valid.
    always @(posedge mclk) begin
        if (spi_cs_n) begin
            spi_din <= #2 ~spi_din;
        end
    end
    task automatic tick(input int k);
        repeat (k) @(posedge mclk);
        #2;
    endtask
    task automatic frame(input logic [15:0] tx, output logic [15:0] rx);
        tick(1);
        spi_cs_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            tick(HALF_CYC);
            spi_sclk = 1'b0;
            spi_din = tx[i];
            tick(HALF_CYC);
            rx[i] = spi_dout;
            spi_sclk = 1'b1;
        end
        tick(HALF_CYC);
        spi_cs_n = 1'b1;
        tick(lp_mode ? 1600 : 200);
    endtask
    task automatic wake();
        tick(1);
        spi_cs_n = 1'b0;
        tick(420);
        spi_cs_n = 1'b1;
        tick(40);
    endtask
    task automatic sync_pulse();
        while (last_sync != 0 && longint'($time) - last_sync < 834000) begin
            tick(1);
        end
        tick(1);
        last_sync = longint'($time);
        sync_clock_input = 1'b1;
        tick(100);
        sync_clock_input = 1'b0;
    endtask
endmodule

// ---- dv/inertial_sensor_spi_timing_tb_top.sv ----
// Purpose: Self-checking bench for the sensor port core.
// Assumes: Shortened delay parameters; the host model drives the serial pins.
// Notes:   A read answers in the frame after its request.
`timescale 1ns/10ps
module inertial_sensor_spi_timing_tb_top;
    localparam int SYD = 100;
    localparam int BASE = 50;
    localparam int RS_L = 2500;
    logic        mclk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        spi_sclk, spi_cs_n, spi_din, spi_dout, spi_dout_oe_n, sync_clock_input;
    logic        ext_sync_enable = 1'b0;
    logic        reset_pin_n = 1'b1;
    logic [15:0] sensor_sample = 16'hA5C3;
    logic        data_ready_pin;
    logic [15:0] v;
    int          bad_count = 0;
    int          samples_checked = 0;
    int          per, wid, n;
    always #25 mclk = ~mclk;
    iss_core #(.START_NORM_CYC(2000), .START_LP_CYC(3000), .RESET_NORM_CYC(1500),
        .RESET_LP_CYC(RS_L), .SLEEP_NORM_CYC(600), .SLEEP_LP_CYC(900),
        .SYNC_DRDY_CYC(SYD), .BASE_CYC(BASE)) u_iss_core (
        .mclk(mclk), .sys_rst(sys_rst), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
        .spi_din(spi_din), .spi_dout(spi_dout), .spi_dout_oe_n(spi_dout_oe_n),
        .sync_clock_input(sync_clock_input), .ext_sync_enable(ext_sync_enable),
        .reset_pin_n(reset_pin_n), .sensor_sample(sensor_sample),
        .data_ready_pin(data_ready_pin));
    iss_host u_iss_host (.mclk(mclk), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
        .spi_din(spi_din), .spi_dout(spi_dout), .sync_clock_input(sync_clock_input));
    task automatic cyc(input int k);
        repeat (k) @(posedge mclk);
        #2;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [6:0] a, output logic [15:0] d);
        logic [15:0] dummy;
        u_iss_host.frame({1'b0, a, 8'h00}, dummy);
        u_iss_host.frame(16'h0000, d);
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [15:0] dummy;
        u_iss_host.frame({1'b1, a, d}, dummy);
    endtask
    task automatic drdy(output int p, output int w);
        p = 0;
        w = 0;
        while (data_ready_pin !== 1'b0 && p < 4000) begin
            cyc(1);
            p++;
        end
        while (data_ready_pin !== 1'b1 && p < 8000) begin
            cyc(1);
            p++;
        end
        p = 0;
        while (data_ready_pin === 1'b1 && w < 100) begin
            cyc(1);
            w++;
            p++;
        end
        while (data_ready_pin !== 1'b1 && p < 4000) begin
            cyc(1);
            p++;
        end
    endtask
    task automatic t_early();
        chk({14'h0, data_ready_pin, spi_dout_oe_n}, 16'h0001);
        rd(7'h00, v);
        chk(v, 16'h0000);
        cyc(2000);
        rd(7'h06, v);
        chk(v, 16'h0001);
        rd(7'h00, v);
        chk(v, 16'hA5C3);
    endtask
    task automatic t_rate();
        logic [7:0] s [3] = '{8'h01, 8'h09, 8'h0A};
        for (int i = 0; i < 3; i++) begin
            u_iss_host.lp_mode = u_iss_host.lp_mode | (s[i] >= 8'h0A);
            wr(7'h04, s[i]);
            u_iss_host.lp_mode = (s[i] >= 8'h0A);
            rd(7'h06, v);
            chk(v, {14'h0, s[i] >= 8'h0A, 1'b1});
            drdy(per, wid);
            drdy(per, wid);
            chk(16'(per), 16'(s[i] * BASE));
            chk(16'(wid), 16'h000A);
        end
        rd(7'h05, v);
        chk(v, 16'h000A);
        wr(7'h05, 8'h05);
        rd(7'h04, v);
        chk(v, 16'h000A);
    endtask
    task automatic t_reset_pin();
        reset_pin_n = 1'b0;
        cyc(10);
        reset_pin_n = 1'b1;
        cyc(1700);
        rd(7'h00, v);
        chk(v, 16'h0000);
        cyc(RS_L);
        rd(7'h06, v);
        chk(v & 16'h0001, 16'h0001);
    endtask
    task automatic t_sleep();
        wr(7'h04, 8'h01);
        u_iss_host.lp_mode = 1'b0;
        wr(7'h06, 8'h01);
        rd(7'h00, v);
        chk(v, 16'h0000);
        u_iss_host.wake();
        rd(7'h00, v);
        chk(v, 16'h0000);
        cyc(600);
        rd(7'h06, v);
        chk(v, 16'h0001);
    endtask
    task automatic t_sync();
        logic [15:0] c0;
        ext_sync_enable = 1'b1;
        cyc(BASE * 2);
        rd(7'h02, c0);
        fork
            u_iss_host.sync_pulse();
            begin
                @(posedge sync_clock_input);
                n = 0;
                while (data_ready_pin !== 1'b1 && n < 1000) begin
                    cyc(1);
                    n++;
                end
            end
        join
        chk(16'(n >= SYD && n <= SYD + 8), 16'h0001);
        rd(7'h02, v);
        chk(v, c0 + 16'h0001);
    endtask
    task automatic close_out();
        $display("checks=%0d mismatches=%0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        cyc(5);
        sys_rst = 1'b0;
        t_early();
        t_rate();
        t_reset_pin();
        t_sleep();
        t_sync();
        close_out();
    end
    initial begin
        #4_000_000;
        bad_count++;
        close_out();
    end
endmodule
